//--- esw_pkg.sv
// Purpose: Shared constants for the write-cycle memory host controller
// Assumes: 100 MHz core clock, 64k x 4 asynchronous memory outside
// Notes: Times in ns as printed, cycle counts derived from the clock period
package esw_pkg;
    localparam int ESW_CLK_PERIOD_NS = 10;
    localparam int ESW_ADDR_W = 16;
    localparam int ESW_DATA_W = 4;
    // Speed grade selection codes
    localparam logic [1:0] ESW_GRADE_12 = 2'h0;
    localparam logic [1:0] ESW_GRADE_15 = 2'h1;
    localparam logic [1:0] ESW_GRADE_18 = 2'h2;
    // Write cycle time per grade
    localparam int ESW_WRITE_CYCLE_TIME_12 = 12;
    localparam int ESW_WRITE_CYCLE_TIME_15 = 15;
    localparam int ESW_WRITE_CYCLE_TIME_18 = 18;
    // Write or select pulse width per grade
    localparam int ESW_PULSE_WIDTH_12 = 9;
    localparam int ESW_PULSE_WIDTH_15 = 10;
    localparam int ESW_PULSE_WIDTH_18 = 12;
    // Data setup to end of write
    localparam int ESW_DATA_SETUP_12 = 9;
    localparam int ESW_DATA_SETUP_15 = 10;
    localparam int ESW_DATA_SETUP_18 = 14;
    // Address setup and address or data hold
    localparam int ESW_ADDR_SETUP_18 = 2;
    localparam int ESW_HOLD_18 = 3;
    // Output low after write start and output valid after write end
    localparam int ESW_WRITE_TO_OUTPUT_LOW_DELAY = 5;
    localparam int ESW_WRITE_END_TO_OUTPUT_VALID_18 = 18;

    function automatic int esw_ceil_cyc(input int ns);
        int c;
        c = (ns + ESW_CLK_PERIOD_NS - 1) / ESW_CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    // Worst grade values cover every grade
    localparam int ESW_SETUP_CYC = esw_ceil_cyc(ESW_ADDR_SETUP_18);
    localparam int ESW_PULSE_CYC_MIN = esw_ceil_cyc(ESW_PULSE_WIDTH_18);
    localparam int ESW_DSETUP_CYC = esw_ceil_cyc(ESW_DATA_SETUP_18);
    localparam int ESW_HOLD_CYC = esw_ceil_cyc(ESW_HOLD_18);
    localparam int ESW_CYCLE_CYC = esw_ceil_cyc(ESW_WRITE_CYCLE_TIME_18);
    localparam int ESW_OUT_LOW_CYC = esw_ceil_cyc(ESW_WRITE_TO_OUTPUT_LOW_DELAY);
    localparam int ESW_OUT_VALID_CYC = esw_ceil_cyc(ESW_WRITE_END_TO_OUTPUT_VALID_18);
    localparam int ESW_PULSE_CYC =
        (ESW_PULSE_CYC_MIN > ESW_DSETUP_CYC) ? ESW_PULSE_CYC_MIN : ESW_DSETUP_CYC;
    localparam int ESW_CNT_W = 4;

    typedef enum logic [2:0] {
        ESW_IDLE = 3'b000,
        ESW_SETUP = 3'b001,
        ESW_PULSE = 3'b010,
        ESW_HOLD = 3'b011,
        ESW_RECOVER = 3'b100,
        ESW_READ = 3'b101
    } esw_state_t;
endpackage

//--- esw_timer.sv
// Purpose: Loadable down counter for phase timing
// Assumes: Load value is at least one
// Notes: done is high while the count is zero
`timescale 1ns/10ps
module esw_timer #(
    parameter int W = 4
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // Control
    input wire logic load,
    input wire logic [W-1:0] value,
    output logic done
);
    logic [W-1:0] cnt_q;

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            cnt_q <= '0;
        else if (load)
            cnt_q <= value;
        else if (cnt_q != '0)
            cnt_q <= cnt_q - 1'b1;
    end

    assign done = (cnt_q == '0);
endmodule

//--- esw_host.sv
// Purpose: Host controller driving writes and reads into a 64k x 4 async memory
// Assumes: Memory pins are synchronous to core_clk; worst grade timing used
// Notes: Select-controlled writes by default; write-enable mode optional
`timescale 1ns/10ps
// Contract
// - Write-enable mode: select falls before write
// - Address held a full write cycle
// - Write enable low at least pulse width
// - Select low pulse width after write falls
// - Address setup before, hold after write
// - Data setup before, hold after write end
// - Select mode swaps select and write roles
// - Prefer select-controlled write on shared buses
// - Address setup/hold around select pulse
// - Select low at least pulse width
// - Write low pulse width after select falls
// - Data setup/hold around select end
module esw_host
#(
    parameter int ADDR_W = esw_pkg::ESW_ADDR_W,
    parameter int DATA_W = esw_pkg::ESW_DATA_W
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // User request
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic req_we_mode,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [DATA_W-1:0] req_wdata,
    output logic req_ready,
    // User answer
    output logic rsp_valid,
    output logic [DATA_W-1:0] rsp_rdata,
    // Memory pins
    output logic [ADDR_W-1:0] word_address,
    output logic [DATA_W-1:0] write_data_in,
    output logic select_n,
    output logic write_n,
    input wire logic [DATA_W-1:0] read_data_out
);
    import esw_pkg::*;

    // ==========================================================
    // State and registers
    esw_state_t state_q, state_d;
    logic we_mode_q;
    logic write_q;
    logic [ADDR_W-1:0] addr_q;
    logic [DATA_W-1:0] wdata_q;
    logic sel_n_q, sel_n_d;
    logic wr_n_q, wr_n_d;
    logic ready_q, rsp_valid_q;
    logic [DATA_W-1:0] rdata_q;
    logic tmr_load;
    logic [ESW_CNT_W-1:0] tmr_value;
    logic tmr_done;
    logic take;
    logic rd_capture;

    localparam logic [ESW_CNT_W-1:0] SETUP_C = ESW_CNT_W'(ESW_SETUP_CYC);
    localparam logic [ESW_CNT_W-1:0] PULSE_C = ESW_CNT_W'(ESW_PULSE_CYC);
    localparam logic [ESW_CNT_W-1:0] HOLD_C = ESW_CNT_W'(ESW_HOLD_CYC);
    localparam logic [ESW_CNT_W-1:0] VALID_C = ESW_CNT_W'(ESW_OUT_VALID_CYC);
    localparam logic [ESW_CNT_W-1:0] CYCLE_C = ESW_CNT_W'(ESW_CYCLE_CYC);

    esw_timer #(.W(ESW_CNT_W)) u_timer (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .load(tmr_load),
        .value(tmr_value),
        .done(tmr_done)
    );

    // ==========================================================
    // Request acceptance
    assign take = ready_q && req_valid;
    // Read data sampled once output-valid time elapsed while select low, write high
    assign rd_capture = (state_q == ESW_READ) && tmr_done;

    // ==========================================================
    // Sequencer
    always_comb
    begin
        state_d = state_q;
        sel_n_d = sel_n_q;
        wr_n_d = wr_n_q;
        tmr_load = 1'b0;
        tmr_value = SETUP_C;
        case (state_q)
            ESW_IDLE:
            begin
                if (take)
                begin
                    // Address settles before any strobe falls
                    state_d = ESW_SETUP;
                    tmr_load = 1'b1;
                    tmr_value = SETUP_C;
                end
            end
            ESW_SETUP:
            begin
                // Write-enable mode: select leads, so write falls on a selected part
                if (write_q && we_mode_q)
                    sel_n_d = 1'b0;
                if (tmr_done)
                begin
                    tmr_load = 1'b1;
                    if (!write_q)
                    begin
                        sel_n_d = 1'b0;
                        state_d = ESW_READ;
                        tmr_value = VALID_C;
                    end
                    else
                    begin
                        // Strobes low; the one that rises later stays low
                        // so the other one ends the write
                        sel_n_d = 1'b0;
                        wr_n_d = 1'b0;
                        state_d = ESW_PULSE;
                        tmr_value = PULSE_C;
                    end
                end
            end
            ESW_PULSE:
            begin
                if (tmr_done)
                begin
                    // Pulse and data setup both met before the ending edge
                    if (we_mode_q)
                        wr_n_d = 1'b1;
                    else
                        sel_n_d = 1'b1;
                    state_d = ESW_HOLD;
                    tmr_load = 1'b1;
                    tmr_value = HOLD_C;
                end
            end
            ESW_HOLD:
            begin
                if (tmr_done)
                begin
                    // Address and data held past the ending edge, then release
                    sel_n_d = 1'b1;
                    wr_n_d = 1'b1;
                    state_d = ESW_RECOVER;
                    tmr_load = 1'b1;
                    tmr_value = CYCLE_C;
                end
            end
            ESW_READ:
            begin
                if (tmr_done)
                begin
                    sel_n_d = 1'b1;
                    state_d = ESW_RECOVER;
                    tmr_load = 1'b1;
                    tmr_value = CYCLE_C;
                end
            end
            ESW_RECOVER:
            begin
                // Full cycle gap before the address may change
                if (tmr_done)
                    state_d = ESW_IDLE;
            end
            default:
            begin
                state_d = ESW_IDLE;
                sel_n_d = 1'b1;
                wr_n_d = 1'b1;
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state_q <= ESW_IDLE;
            sel_n_q <= 1'b1;
            wr_n_q <= 1'b1;
        end
        else
        begin
            state_q <= state_d;
            sel_n_q <= sel_n_d;
            wr_n_q <= wr_n_d;
        end
    end

    // ==========================================================
    // Captured request; address stays put until idle again
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            addr_q <= '0;
            wdata_q <= '0;
            write_q <= 1'b0;
            we_mode_q <= 1'b0;
        end
        else if (take)
        begin
            addr_q <= req_addr;
            wdata_q <= req_wdata;
            write_q <= req_write;
            we_mode_q <= req_we_mode;
        end
    end

    // ==========================================================
    // Handshake and read return
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            ready_q <= 1'b0;
            rsp_valid_q <= 1'b0;
            rdata_q <= '0;
        end
        else
        begin
            ready_q <= (state_d == ESW_IDLE) && !take;
            rsp_valid_q <= rd_capture;
            if (rd_capture)
                rdata_q <= read_data_out;
        end
    end

    assign req_ready = ready_q;
    assign rsp_valid = rsp_valid_q;
    assign rsp_rdata = rdata_q;
    assign word_address = addr_q;
    assign write_data_in = wdata_q;
    assign select_n = sel_n_q;
    assign write_n = wr_n_q;
endmodule

//--- esw_mem_model.sv
// Purpose: Behavioural 64k x 4 asynchronous memory facing the host
// Assumes: Strobes active low; outputs sit low unless reading
// Notes: VALID_NS sets how slowly read data appears
`timescale 1ns/10ps
module esw_mem_model #(
    parameter int VALID_NS = 15
) (
    // Memory pins
    input wire logic [15:0] word_address,
    input wire logic [3:0] write_data_in,
    input wire logic select_n,
    input wire logic write_n,
    output logic [3:0] read_data_out
);
    logic [3:0] store [0:65535];
    logic wr_on = 1'b0;
    logic rd_late = 1'b0;
    logic rd_on;
    // ====
    // Storage
    initial
    begin
        for (int i = 0; i < 65536; i++)
            store[i] = 4'(i) ^ 4'(i >> 12);
    end
    always @(select_n or write_n)
    begin
        if (!select_n && !write_n)
            wr_on = 1'b1;
        else if (wr_on)
        begin
            // First strobe to rise ends the write
            store[word_address] = write_data_in;
            wr_on = 1'b0;
        end
    end
    // ====
    // Read path
    assign rd_on = !select_n && write_n;
    always @(rd_on)
        rd_late <= #(VALID_NS) rd_on;
    // Low at once on deselect or write start
    assign read_data_out = (rd_on && rd_late) ? store[word_address] : 4'h0;
endmodule

//--- esw_host_chk.sv
// Purpose: Pin timing checks for the memory host controller
// Assumes: One cycle of 10 ns covers each 0 to 3 ns margin
// Notes: Mode and direction latched at each accepted request
`timescale 1ns/10ps
module esw_host_chk
    import esw_pkg::*;
#(
    parameter int ADDR_W = 16,
    parameter int DATA_W = 4
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // User side
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic req_we_mode,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [DATA_W-1:0] req_wdata,
    input wire logic req_ready,
    input wire logic rsp_valid,
    input wire logic [DATA_W-1:0] rsp_rdata,
    // Memory side
    input wire logic [ADDR_W-1:0] word_address,
    input wire logic [DATA_W-1:0] write_data_in,
    input wire logic select_n,
    input wire logic write_n,
    input wire logic [DATA_W-1:0] read_data_out
);
    logic mode_q;
    logic wr_q;
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            mode_q <= 1'b0;
            wr_q <= 1'b0;
        end
        else if (req_valid && req_ready)
        begin
            mode_q <= req_we_mode;
            wr_q <= req_write;
        end
    end
    // ====
    // Assertions
    chk_select_low: assert property ($fell(select_n) |-> !select_n [*2])
        else $error("select pulse too short");
    chk_write_low: assert property ($fell(write_n) |-> !write_n [*2])
        else $error("write pulse too short");
    chk_select_over_write: assert property ($fell(write_n) |-> !select_n [*2])
        else $error("select not low across write");
    chk_addr_setup: assert property ($fell(select_n) || $fell(write_n) |-> $stable(word_address))
        else $error("address moved at strobe fall");
    chk_addr_held: assert property (!select_n || !write_n |-> $stable(word_address))
        else $error("address moved during cycle");
    chk_hold_after: assert property ($rose(select_n) || $rose(write_n)
        |-> $stable(word_address) && $stable(write_data_in))
        else $error("address or data not held");
    chk_data_setup: assert property ($rose(select_n) && wr_q
        |-> write_data_in == $past(write_data_in, 2))
        else $error("data setup too short");
    chk_end_order: assert property ($rose(select_n) && wr_q |-> write_n == mode_q)
        else $error("wrong strobe ended the write");
    chk_read_no_write: assert property (!wr_q |-> write_n)
        else $error("write strobe during read");
    chk_read_answer: assert property (req_valid && req_ready && !req_write |-> ##6 rsp_valid)
        else $error("read answer missing");
    chk_select_first: assert property ($fell(write_n) && mode_q |-> !$past(select_n))
        else $error("select not low before write in write-enable mode");
    chk_write_first: assert property ($fell(select_n) && wr_q && !mode_q |-> !write_n)
        else $error("write not low at select fall in select mode");
    cover property (req_valid && req_ready && req_write && !req_we_mode);
    cover property (req_valid && req_ready && req_write && req_we_mode);
    cover property (rsp_valid);
endmodule
bind esw_host esw_host_chk #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_chk (
    .core_clk(core_clk), .sys_rst(sys_rst), .req_valid(req_valid), .req_write(req_write),
    .req_we_mode(req_we_mode), .req_addr(req_addr), .req_wdata(req_wdata),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .word_address(word_address), .write_data_in(write_data_in), .select_n(select_n),
    .write_n(write_n), .read_data_out(read_data_out)
);

//--- tb.sv
// Purpose: Self-checking bench for the memory host controller
// Assumes: Inputs change on the falling edge only
// Notes: Narrow random address set so reads often hit earlier writes
`timescale 1ns/10ps
module tb;
    import esw_pkg::*;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic req_valid = 1'b0;
    logic req_write = 1'b0;
    logic req_we_mode = 1'b0;
    logic [15:0] req_addr = 16'h0000;
    logic [3:0] req_wdata = 4'h0;
    logic req_ready, rsp_valid, select_n, write_n;
    logic [3:0] rsp_rdata, write_data_in, read_data_out;
    logic [15:0] word_address;
    logic [3:0] shadow [logic [15:0]];
    logic [31:0] rng_state = 32'h0000_005f;
    logic [31:0] r;
    int fail_count = 0;
    int total_checks = 0;
    esw_host DUT (.core_clk(core_clk), .sys_rst(sys_rst), .req_valid(req_valid),
        .req_write(req_write), .req_we_mode(req_we_mode), .req_addr(req_addr),
        .req_wdata(req_wdata), .req_ready(req_ready), .rsp_valid(rsp_valid),
        .rsp_rdata(rsp_rdata), .word_address(word_address), .write_data_in(write_data_in),
        .select_n(select_n), .write_n(write_n), .read_data_out(read_data_out));
    esw_mem_model #(.VALID_NS(15)) u_mem (.word_address(word_address),
        .write_data_in(write_data_in), .select_n(select_n), .write_n(write_n),
        .read_data_out(read_data_out));
    initial
    begin
        forever #5 core_clk = ~core_clk;
    end
    // ====
    // Helpers
    function automatic logic [31:0] next_rand();
        rng_state = rng_state ^ (rng_state << 13);
        rng_state = rng_state ^ (rng_state >> 17);
        rng_state = rng_state ^ (rng_state << 5);
        return rng_state;
    endfunction
    function automatic logic [3:0] expect_word(input logic [15:0] a);
        return shadow.exists(a) ? shadow[a] : (a[3:0] ^ a[15:12]);
    endfunction
    task automatic check4(input string what, input logic [3:0] exp, input logic [3:0] got);
        total_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Raised once ready is seen high or after 40 falling edges without it, dropped after the taking edge
    task automatic do_req(input logic wr, input logic mode, input logic [15:0] a,
                          input logic [3:0] d);
        int n;
        n = 0;
        while (req_ready !== 1'b1 && n < 40)
        begin
            @(negedge core_clk);
            n++;
        end
        check4("request ready", 4'h1, 4'(req_ready));
        req_valid = 1'b1;
        req_write = wr;
        req_we_mode = mode;
        req_addr = a;
        req_wdata = d;
        @(negedge core_clk);
        req_valid = 1'b0;
        if (wr)
            shadow[a] = d;
        else
        begin
            n = 0;
            while (rsp_valid !== 1'b1 && n < 12)
            begin
                @(negedge core_clk);
                n++;
            end
            check4("read answer", 4'h1, 4'(rsp_valid));
            check4("read word", expect_word(a), rsp_rdata);
        end
    endtask
    // ====
    // Main sequence
    initial
    begin
        repeat (6) @(negedge core_clk);
        check4("idle strobes", 4'h3, {2'b00, select_n, write_n});
        sys_rst = 1'b0;
        repeat (2) @(negedge core_clk);
        do_req(1'b1, 1'b0, 16'h0000, 4'hf);
        do_req(1'b1, 1'b1, 16'hffff, 4'h0);
        do_req(1'b0, 1'b0, 16'h0000, 4'h0);
        do_req(1'b0, 1'b0, 16'hffff, 4'h0);
        do_req(1'b0, 1'b0, 16'h1234, 4'h0);
        repeat (300)
        begin
            r = next_rand();
            do_req(r[0], r[1], r[31:16] & 16'hc00f, r[7:4]);
        end
        tally_and_finish();
    end
    initial
    begin
        #100000;
        fail_count++;
        tally_and_finish();
    end
endmodule
